// *** hdl/txcu_lane_en.sv ***
// txcu_lane_en: byte enables of one payload word
`timescale 1ns/10ps
`default_nettype none
module txcu_lane_en
(
   input wire logic first,
   input wire logic last,
   input wire logic [1:0] first_lane,
   input wire logic [1:0] last_lane,
   output logic [3:0] be
);
   always_comb
   begin
      for (int i = 0; i < 4; i++)
      begin
         be[i] = (!first || (2'(i) >= first_lane)) && (!last || (2'(i) <= last_lane));
      end
   end
endmodule : txcu_lane_en
`default_nettype wire

// *** hdl/txcu_pkg.sv ***
// txcu_pkg: field layout, register map and shared helpers of the command word unpacker
package txcu_pkg;

   // ---------------------------------------------
   // first command word fields
   // ---------------------------------------------
   localparam int A_ALIGN_HI = 25;
   localparam int A_ALIGN_LO = 24;
   localparam int A_OFF_HI = 20;
   localparam int A_OFF_LO = 16;
   localparam int A_FS_BIT = 13;
   localparam int A_LS_BIT = 12;
   localparam int A_SIZE_HI = 10;
   localparam logic [31:0] A_RSVD_MASK = 32'h7CE0C800;

   // ---------------------------------------------
   // second command word fields
   // ---------------------------------------------
   localparam int B_TAG_HI = 31;
   localparam int B_TAG_LO = 16;
   localparam int B_NOCRC_BIT = 13;
   localparam int B_NOPAD_BIT = 12;
   localparam int B_LEN_HI = 10;

   // ---------------------------------------------
   // end alignment codes and round-up masks
   // ---------------------------------------------
   localparam logic [1:0] ALIGN_4 = 2'h0;
   localparam logic [1:0] ALIGN_16 = 2'h1;
   localparam logic [1:0] ALIGN_32 = 2'h2;
   localparam logic [1:0] ALIGN_RSVD = 2'h3;
   localparam logic [12:0] MASK_4 = 13'h0003;
   localparam logic [12:0] MASK_16 = 13'h000F;
   localparam logic [12:0] MASK_32 = 13'h001F;

   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_MASK = 4'h4;
   localparam logic [3:0] REG_LASTPKT = 4'h8;
   localparam logic [3:0] REG_INFO = 4'hC;
   localparam int ST_TXE = 0;
   localparam int ST_PKT = 1;
   localparam int ST_W = 2;
   localparam logic [ST_W-1:0] STATUS_RST = 2'h0;
   localparam logic [ST_W-1:0] MASK_RST = 2'h0;

   typedef enum logic [1:0] {TXCU_CMDA, TXCU_CMDB, TXCU_DATA} txcu_state_e;

   // round a byte count up to the boundary given by a low-bit mask
   function automatic logic [12:0] txcu_round_up(input logic [12:0] v, input logic [12:0] m);
      return (v + m) & ~m;
   endfunction : txcu_round_up

endpackage : txcu_pkg

// *** hdl/txcu_span.sv ***
// txcu_span: word counts of one buffer from offset, size and end alignment
`timescale 1ns/10ps
`default_nettype none
module txcu_span
   import txcu_pkg::*;
(
   input wire logic [4:0] off,
   input wire logic [10:0] size,
   input wire logic [1:0] align,
   output logic [2:0] skip,
   output logic [10:0] payload,
   output logic [10:0] total,
   output logic [1:0] last_lane
);
   logic [12:0] amask;
   logic [12:0] tot_bytes;
   logic [12:0] pay_bytes;

   always_comb
   begin
      case (align)
         ALIGN_16: amask = MASK_16;
         ALIGN_32: amask = MASK_32;
         default: amask = MASK_4;
      endcase
   end

   assign skip = off[4:2];
   assign tot_bytes = txcu_round_up({8'h00, off} + {2'h0, size}, amask);
   assign pay_bytes = txcu_round_up({11'h000, off[1:0]} + {2'h0, size}, MASK_4);
   assign total = tot_bytes[12:2];
   assign payload = pay_bytes[12:2];
   assign last_lane = 2'(off[1:0] + size[1:0] - 2'h1);

endmodule : txcu_span
`default_nettype wire

// *** hdl/txcu_top.sv ***
// txcu_top: transmit command word unpacker with register port and interrupt
// ---------------------------------------------
// Summary of operation
// - bits 20:16 give start offset 0-31
// - bit 13 marks first segment
// - bit 12 marks last segment
// - bits 10:0 give buffer payload bytes
// - compute and discard trailing pad words
// - sum buffer sizes, flag length mismatch
// - copy tag into packet status
// - bit 13 suppresses appended frame check
// - no-pad bit keeps frame check appended
// - bits 10:0 give packet length, checked
// - payload starts at third word
// - offset low bits pick first lane
// - offset high bits skip whole words
// - lane map 00..11 to bytes 0..3
// - end alignment 4/16/32, code 11 reserved
// - second word equal across packet buffers
// ---------------------------------------------
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
module txcu_top
   import txcu_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic [31:0] WR_DATA,
   input wire logic WR_VALID,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic [31:0] TXD_DATA,
   output logic [3:0] TXD_BE,
   output logic TXD_VALID,
   output logic TXD_SOP,
   output logic TXD_EOP,
   output logic TXD_NOCRC,
   output logic TXD_NOPAD,
   output logic STAT_VALID,
   output logic [15:0] STAT_TAG,
   output logic STAT_ERR,
   output logic IRQ
);
   // ---------------------------------------------
   // state and held command fields
   // ---------------------------------------------
   txcu_state_e state;
   txcu_state_e next_state;
   logic [10:0] idx;
   logic [31:0] a_word;
   logic [31:0] b_saved;
   logic in_pkt;
   logic pkt_err;
   logic [11:0] acc;
   logic [11:0] next_acc;
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] mask;
   logic [ST_W-1:0] next_status;
   logic [ST_W-1:0] next_mask;
   logic [15:0] last_tag;
   logic last_err;

   logic [4:0] a_off;
   logic [10:0] a_size;
   logic [1:0] a_align;
   logic a_fs;
   logic a_ls;
   logic [2:0] skip;
   logic [10:0] payload;
   logic [10:0] total;
   logic [1:0] last_lane;
   logic [10:0] skip_ext;
   logic [10:0] pay_end;
   logic [3:0] be;
   logic wr_a;
   logic wr_b;
   logic wr_d;
   logic in_pay;
   logic pay_first;
   logic pay_last;
   logic buf_end;
   logic pkt_end;
   logic [31:0] b_cur;
   logic b_mismatch;
   logic orphan;
   logic align_bad;
   logic len_bad;
   logic txe_evt;

   assign a_off = a_word[A_OFF_HI:A_OFF_LO];
   assign a_size = a_word[A_SIZE_HI:0];
   assign a_align = a_word[A_ALIGN_HI:A_ALIGN_LO];
   assign a_fs = a_word[A_FS_BIT];
   assign a_ls = a_word[A_LS_BIT];

   txcu_span u_span
   (
      .off(a_off),
      .size(a_size),
      .align(a_align),
      .skip(skip),
      .payload(payload),
      .total(total),
      .last_lane(last_lane)
   );

   // first lane from offset low bits
   txcu_lane_en u_lane
   (
      .first(pay_first),
      .last(pay_last),
      .first_lane(a_off[1:0]),
      .last_lane(last_lane),
      .be(be)
   );

   // ---------------------------------------------
   // word classification
   // ---------------------------------------------
   assign wr_a = WR_VALID && (state == TXCU_CMDA);
   assign wr_b = WR_VALID && (state == TXCU_CMDB);
   assign wr_d = WR_VALID && (state == TXCU_DATA);
   assign skip_ext = {8'h00, skip};
   assign pay_end = skip_ext + payload;
   // words below skip carry no payload
   assign in_pay = wr_d && (idx >= skip_ext) && (idx < pay_end);
   assign pay_first = (idx == skip_ext);
   assign pay_last = (idx == pay_end - 11'h001);
   // buffer ends after the last pad word
   assign buf_end = (wr_b && (total == 11'h000)) || (wr_d && (idx == total - 11'h001));
   assign pkt_end = buf_end && a_ls;
   assign b_cur = wr_b ? WR_DATA : b_saved;

   // ---------------------------------------------
   // error detection
   // ---------------------------------------------
   // repeated second word must match
   assign b_mismatch = wr_b && !a_fs && in_pkt && (WR_DATA != b_saved);
   assign orphan = wr_b && !a_fs && !in_pkt;
   assign align_bad = wr_b && (a_align == ALIGN_RSVD);
   assign len_bad = pkt_end && (next_acc != {1'b0, b_cur[B_LEN_HI:0]});
   assign txe_evt = b_mismatch || orphan || align_bad || len_bad;

   always_comb
   begin
      next_acc = acc;
      if (wr_b)
      begin
         next_acc = (a_fs ? 12'h000 : acc) + {1'b0, a_size};
      end
   end

   // ---------------------------------------------
   // word sequencer
   // ---------------------------------------------
   // fixed order of words
   always_comb
   begin
      next_state = state;
      case (state)
         TXCU_CMDA: if (wr_a) next_state = TXCU_CMDB;
         TXCU_CMDB: if (wr_b) next_state = buf_end ? TXCU_CMDA : TXCU_DATA;
         TXCU_DATA: if (buf_end) next_state = TXCU_CMDA;
         default: next_state = TXCU_CMDA;
      endcase
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         state <= TXCU_CMDA;
      end
      else
      begin
         state <= next_state;
      end
   end

   // data index starts at third word
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         idx <= 11'h000;
      end
      else if (wr_b)
      begin
         idx <= 11'h000;
      end
      else if (wr_d)
      begin
         idx <= idx + 11'h001;
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         a_word <= 32'h00000000;
      end
      else if (wr_a)
      begin
         a_word <= WR_DATA;
      end
   end

   // packet context: second word, byte sum, open packet
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         b_saved <= 32'h00000000;
         acc <= 12'h000;
         in_pkt <= 1'b0;
         pkt_err <= 1'b0;
      end
      else
      begin
         acc <= next_acc;
         if (wr_b && (a_fs || !in_pkt))
         begin
            b_saved <= WR_DATA;
         end
         if (pkt_end)
         begin
            in_pkt <= 1'b0;
            pkt_err <= 1'b0;
         end
         else
         begin
            if (wr_b)
            begin
               in_pkt <= 1'b1;
            end
            if (wr_b && a_fs)
            begin
               pkt_err <= txe_evt;
            end
            else if (txe_evt)
            begin
               pkt_err <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------
   // payload word output
   // ---------------------------------------------
   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         TXD_DATA <= 32'h00000000;
         TXD_BE <= 4'h0;
         TXD_VALID <= 1'b0;
         TXD_SOP <= 1'b0;
         TXD_EOP <= 1'b0;
         TXD_NOCRC <= 1'b0;
         TXD_NOPAD <= 1'b0;
      end
      else
      begin
         TXD_VALID <= in_pay;
         TXD_BE <= in_pay ? be : 4'h0;
         TXD_SOP <= in_pay && pay_first && a_fs;
         TXD_EOP <= in_pay && pay_last && a_ls;
         if (in_pay)
         begin
            TXD_DATA <= WR_DATA;
            TXD_NOCRC <= b_saved[B_NOCRC_BIT] && !b_saved[B_NOPAD_BIT];
            TXD_NOPAD <= b_saved[B_NOPAD_BIT];
         end
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         STAT_VALID <= 1'b0;
         STAT_TAG <= 16'h0000;
         STAT_ERR <= 1'b0;
         last_tag <= 16'h0000;
         last_err <= 1'b0;
      end
      else
      begin
         STAT_VALID <= pkt_end;
         if (pkt_end)
         begin
            STAT_TAG <= b_cur[B_TAG_HI:B_TAG_LO];
            STAT_ERR <= txe_evt || (pkt_err && !(wr_b && a_fs));
            last_tag <= b_cur[B_TAG_HI:B_TAG_LO];
            last_err <= txe_evt || (pkt_err && !(wr_b && a_fs));
         end
      end
   end

   // ---------------------------------------------
   // registers and interrupt
   // ---------------------------------------------
   // sticky transmit error flag, set beats clear
   always_comb
   begin
      next_status = status;
      next_mask = mask;
      if (REG_WR && (REG_ADDR == REG_STATUS))
      begin
         next_status = status & ~REG_WDATA[ST_W-1:0];
      end
      if (REG_WR && (REG_ADDR == REG_MASK))
      begin
         next_mask = REG_WDATA[ST_W-1:0];
      end
      next_status[ST_TXE] = next_status[ST_TXE] || txe_evt;
      next_status[ST_PKT] = next_status[ST_PKT] || pkt_end;
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         status <= STATUS_RST;
         mask <= MASK_RST;
         IRQ <= 1'b0;
      end
      else
      begin
         status <= next_status;
         mask <= next_mask;
         IRQ <= |(next_status & next_mask);
      end
   end

   always_ff @(posedge CLK_SYS)
   begin
      if (!NRST)
      begin
         REG_RDATA <= 32'h00000000;
      end
      else if (REG_RD)
      begin
         case (REG_ADDR)
            REG_STATUS: REG_RDATA <= {30'h00000000, status};
            REG_MASK: REG_RDATA <= {30'h00000000, mask};
            REG_LASTPKT: REG_RDATA <= {last_tag, 15'h0000, last_err};
            REG_INFO: REG_RDATA <= {13'h0000, in_pkt, state, 4'h0, acc};
            default: REG_RDATA <= 32'h00000000;
         endcase
      end
      else
      begin
         REG_RDATA <= 32'h00000000;
      end
   end

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);

   sequence s_cmd_pair;
      wr_a ##1 wr_b;
   endsequence

   a_cmd_order: assert property (wr_a |=> state == TXCU_CMDB)
      else $error("first command word not followed by second");
   a_data_third: assert property (s_cmd_pair ##1 (WR_VALID && (a_off[4:2] == 3'h0) && (a_size != 11'h000)) |=> TXD_VALID && (TXD_DATA == $past(WR_DATA)))
      else $error("third word not forwarded as payload");
   a_skip_words: assert property (wr_d && (idx < skip_ext) |=> !TXD_VALID)
      else $error("skipped offset word was forwarded");
   a_pad_drop: assert property (wr_d && (idx >= pay_end) |=> !TXD_VALID)
      else $error("padding word was forwarded");
   a_first_lane: assert property (in_pay && pay_first |=> TXD_BE[a_off[1:0]] && ((a_off[1:0] == 2'h0) || !TXD_BE[0]))
      else $error("first byte lane wrong");
   a_b_match: assert property (b_mismatch |=> status[ST_TXE] ##1 status[ST_TXE] || $past(REG_WR))
      else $error("second word mismatch not flagged");
   a_len_flag: assert property (len_bad |=> status[ST_TXE] && STAT_VALID && STAT_ERR)
      else $error("length mismatch not flagged");
   a_tag_copy: assert property (pkt_end |=> STAT_VALID && (STAT_TAG == $past(b_cur[B_TAG_HI:B_TAG_LO])))
      else $error("packet tag not copied");
   a_crc_ctrl: assert property (TXD_VALID |-> TXD_NOCRC == (b_saved[B_NOCRC_BIT] && !b_saved[B_NOPAD_BIT]))
      else $error("frame check control wrong");
   a_align_rsvd: assert property (align_bad |=> status[ST_TXE])
      else $error("reserved alignment not flagged");

endmodule : txcu_top
`default_nettype wire

// *** sim/tb.sv ***
// tb: self-checking bench of the command word unpacker
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module tb
   import txcu_pkg::*;
   ;
   logic CLK_SYS, NRST, WR_VALID, REG_WR, REG_RD, TXD_VALID, TXD_SOP, TXD_EOP;
   logic TXD_NOCRC, TXD_NOPAD, STAT_VALID, STAT_ERR, IRQ, lerr;
   logic [31:0] WR_DATA, REG_WDATA, REG_RDATA, TXD_DATA, r;
   logic [3:0] REG_ADDR, TXD_BE;
   logic [15:0] STAT_TAG, ltag;
   logic [1:0] mk, st;
   logic [39:0] ew;
   logic [16:0] es;
   logic [39:0] eq[$];
   logic [16:0] sq[$];
   int mismatches = 0;
   int comparisons = 0;
   int acc_m = 0;

   txcu_host i_host (.clk_sys(CLK_SYS), .wr_data(WR_DATA), .wr_valid(WR_VALID));
   txcu_top i_dut (.CLK_SYS(CLK_SYS), .NRST(NRST), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .TXD_DATA(TXD_DATA), .TXD_BE(TXD_BE), .TXD_VALID(TXD_VALID),
      .TXD_SOP(TXD_SOP), .TXD_EOP(TXD_EOP), .TXD_NOCRC(TXD_NOCRC), .TXD_NOPAD(TXD_NOPAD),
      .STAT_VALID(STAT_VALID), .STAT_TAG(STAT_TAG), .STAT_ERR(STAT_ERR), .IRQ(IRQ));

   initial
   begin
      CLK_SYS = 1'b0;
      forever #25 CLK_SYS = ~CLK_SYS;
   end

   function automatic logic [31:0] bm(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : bm

   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   // ---------------------------------------------
   // output monitors against the model queues
   // ---------------------------------------------
   always @(negedge CLK_SYS)
   begin
      if (TXD_VALID === 1'b1)
      begin
         ew = (eq.size() > 0) ? eq.pop_front() : 'x;
         `CHK({TXD_SOP, TXD_EOP, TXD_NOCRC, TXD_NOPAD, TXD_BE, TXD_DATA & bm(TXD_BE)}, ew)
      end
      if (STAT_VALID === 1'b1)
      begin
         es = (sq.size() > 0) ? sq.pop_front() : 'x;
         `CHK({STAT_TAG, STAT_ERR}, es)
      end
   end

   // ---------------------------------------------
   // register port
   // ---------------------------------------------
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
      @(negedge CLK_SYS);
   endtask : reg_wr

   task automatic reg_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge CLK_SYS);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      @(negedge CLK_SYS);
      `CHK(REG_RDATA, e)
   endtask : reg_chk

   // ---------------------------------------------
   // one packet: model words, then host writes
   // ---------------------------------------------
   task automatic pkt(input int nseg, input int bad);
      int sz[4];
      int len, off, al, ab, tw, lo, hi, np, k;
      logic [31:0] a, b, bs, w, q;
      logic [31:0] d[$];
      logic [3:0] be;
      logic fs;
      len = 0;
      for (int s = 0; s < nseg; s++)
      begin
         sz[s] = $urandom_range(4, 40);
         len += sz[s];
      end
      q = $urandom;
      if (bad == 1)
         len++;
      b = {q[31:16], 2'h0, q[1], q[0], 1'h0, 11'(len)};
      ltag = q[31:16];
      lerr = (bad != 0);
      for (int s = 0; s < nseg; s++)
      begin
         q = $urandom;
         off = q[4:0];
         al = (bad == 2 && s == 0) ? 3 : q[9:8] % 3;
         ab = (al == 1) ? 16 : (al == 2) ? 32 : 4;
         tw = (off + sz[s] + ab - 1) / ab * ab / 4;
         lo = off % 4;
         np = (lo + sz[s] + 3) / 4;
         hi = (lo + sz[s] - 1) % 4;
         // altered second word on a later buffer
         bs = (bad == 3 && s == 1) ? b ^ 32'h00010000 : b;
         // bad 4 leaves the opening flag off, no packet open
         fs = (s == 0) && (bad != 4);
         // running byte sum as the device keeps it
         acc_m = (fs ? 0 : acc_m) + sz[s];
         a = {6'h0, 2'(al), 3'h0, 5'(off), 2'h0, fs, s == nseg - 1, 1'h0, 11'(sz[s])};
         d = {};
         for (int i = 0; i < tw; i++)
         begin
            w = $urandom;
            d.push_back(w);
            k = i - off / 4;
            if (k >= 0 && k < np)
            begin
               be = 4'hF;
               if (k == 0)
                  be &= 4'hF << lo;
               if (k == np - 1)
                  be &= 4'hF >> (3 - hi);
               eq.push_back({fs && k == 0, s == nseg - 1 && k == np - 1, b[13] & ~b[12],
                             b[12], be, w & bm(be)});
            end
         end
         i_host.send_buf(a, bs, d, s == nseg - 1);
      end
      sq.push_back({ltag, lerr});
   endtask : pkt

   initial
   begin
      repeat (30000) @(posedge CLK_SYS);
      mismatches++;
      complete_run();
   end

   initial
   begin
      NRST = 1'b0;
      REG_ADDR = 4'h0;
      REG_WDATA = 32'h0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      void'($urandom(32'hB608));
      repeat (10) @(posedge CLK_SYS);
      NRST <= 1'b1;
      reg_chk(REG_STATUS, 32'h0);
      reg_chk(REG_MASK, 32'h0);
      for (int n = 0; n < 40; n++)
      begin
         r = $urandom;
         i_host.slow = r[0];
         mk = r[2:1];
         reg_wr(REG_MASK, {30'h0, mk});
         pkt(1 + n % 3, (n % 3 == 0) ? 4 * int'(r[6]) : int'(r[5:4]));
         repeat (3) @(posedge CLK_SYS);
         `CHK(eq.size() + sq.size(), 0)
         st = {1'b1, lerr};
         `CHK(IRQ, |(st & mk))
         reg_chk(REG_STATUS, {30'h0, st});
         reg_chk(REG_LASTPKT, {ltag, 15'h0, lerr});
         reg_wr(REG_STATUS, 32'h3);
         `CHK(IRQ, 1'b0)
         reg_chk(REG_STATUS, 32'h0);
      end
      reg_chk(REG_INFO, {20'h0, 12'(acc_m)});
      reg_chk(4'h2, 32'h0);
      reg_wr(4'h6, 32'hFFFFFFFF);
      reg_chk(REG_MASK, {30'h0, mk});
      complete_run();
   end
endmodule : tb
`default_nettype wire

// *** sim/txcu_host.sv ***
// txcu_host: host model writing command words and buffer data into the transmit fifo
`timescale 1ns/10ps
`default_nettype none
module txcu_host
(
   input wire logic clk_sys,
   output logic [31:0] wr_data,
   output logic wr_valid
);
   bit slow;

   initial
   begin
      wr_data = 32'h0;
      wr_valid = 1'b0;
      slow = 1'b0;
   end

   // ---------------------------------------------
   // one word, at random one idle cycle before it when slow
   // ---------------------------------------------
   task automatic put(input logic [31:0] w);
      if (slow && $urandom_range(0, 1))
      begin
         @(posedge clk_sys);
         wr_valid <= 1'b0;
         wr_data <= ~wr_data;
      end
      @(posedge clk_sys);
      wr_data <= w;
      wr_valid <= 1'b1;
   endtask : put

   // ---------------------------------------------
   // one buffer: word a, word b, then data and pad
   // ---------------------------------------------
   // both command words first
   // pad words come from the caller
   task automatic send_buf(input logic [31:0] a, input logic [31:0] b, input logic [31:0] d[$],
                           input bit fin);
      put(a);
      put(b);
      foreach (d[i])
         put(d[i]);
      if (fin)
      begin
         @(posedge clk_sys);
         wr_valid <= 1'b0;
         wr_data <= ~wr_data;
      end
   endtask : send_buf
endmodule : txcu_host
`default_nettype wire
